// file: logic/chan_seq_pkg.sv
package chan_seq_pkg;
	// Clock and time base
	localparam int          CLK_NS      = 10;
	localparam int          TICK_NS     = 1000;
	localparam int          TICK_CYCLES = TICK_NS / CLK_NS;
	localparam logic [6:0]  TICK_LAST   = 7'(TICK_CYCLES - 1);
	localparam int          CTRL_LOW_US = 10;
	localparam logic [3:0]  CTRL_LOW_TK = 4'(CTRL_LOW_US * 1000 / TICK_NS);
	// Sizes
	localparam int NCH   = 4;
	localparam int NPIN  = 2;
	localparam int DAC_W = 10;
	localparam int NWORD = 7;
	// Global register offsets
	localparam logic [11:0] OFS_OPERATION = 12'h000;
	localparam logic [11:0] OFS_VIN_LIMIT = 12'h004;
	localparam logic [11:0] OFS_RESTART   = 12'h008;
	localparam logic [11:0] OFS_STATUS    = 12'h00c;
	localparam logic [11:0] OFS_STATE     = 12'h010;
	localparam logic [11:0] OFS_CH_BASE   = 12'h040;
	localparam logic [11:0] OFS_CH_END    = 12'h0c0;
	// Per-channel word index (stride 0x20)
	localparam logic [2:0] CW_CFG    = 3'h0;
	localparam logic [2:0] CW_TON    = 3'h1;
	localparam logic [2:0] CW_TOFF   = 3'h2;
	localparam logic [2:0] CW_VCMD   = 3'h3;
	localparam logic [2:0] CW_MARGIN = 3'h4;
	localparam logic [2:0] CW_FAULT  = 3'h5;
	localparam logic [2:0] CW_WARN   = 3'h6;
	// channel_config fields
	localparam int CFG_SRC    = 0;
	localparam int CFG_TRACK  = 2;
	localparam int CFG_PIN    = 3;
	localparam int CFG_DACM   = 4;
	localparam int CFG_WSERVO = 6;
	localparam int CFG_CONT   = 7;
	localparam int CFG_IGN_OV = 8;
	localparam int CFG_UV_OFF = 9;
	localparam int CFG_DAC    = 16;
	localparam int DISCH_LSB  = 16;
	// Operation register: on bit and margin pair per channel nibble
	localparam int OP_STRIDE = 4;
	localparam int OP_MRG    = 1;
	localparam logic [1:0] SRC_VIN  = 2'h0;
	localparam logic [1:0] SRC_OP   = 2'h1;
	localparam logic [1:0] SRC_PIN  = 2'h2;
	localparam logic [1:0] SRC_BOTH = 2'h3;
	localparam logic [1:0] DM_SERVO    = 2'h0;
	localparam logic [1:0] DM_OFF      = 2'h1;
	localparam logic [1:0] DM_MAN_SOFT = 2'h2;
	localparam logic [1:0] DM_MAN_HARD = 2'h3;
	localparam logic [1:0] MRG_NOM  = 2'h0;
	localparam logic [1:0] MRG_LOW  = 2'h1;
	localparam logic [1:0] MRG_HIGH = 2'h2;
	// Reset values; discharge factor 0xc0 = 0.75 of commanded voltage
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [31:0] VCMD_RESET = 32'h00c0_0000;
	typedef enum logic [2:0] {
		CH_OFF, CH_WAIT_ON, CH_RISE, CH_ON, CH_OFF_WAIT
	} chan_state_type;
endpackage

// file: logic/channel_sequence_servo_margin.sv
// Functional notes
// - Pins and operation commands ignored until input voltage passes on level.
// - Input below off level turns all off, immediate or sequenced by track bit.
// - Turn-on source per channel: input only, command, pin, or both.
// - Converter enable rises after turn-on delay from sequence start.
// - After rise time the DAC soft-connects and servos to commanded voltage.
// - At maximum turn-on time check undervoltage; optionally disable, drive fault.
// - Overvoltage checked always, except margining set to ignore it.
// - In ON state the command selects margin high, low or nominal.
// - Continuous trim updates DAC after every output reading.
// - Non-continuous trim stops updating DAC once target is read.
// - Non-continuous with warn servo re-servos outside warning limits.
// - Soft-connect brings DAC within one LSB of feedback before connecting.
// - Disconnected mode keeps the DAC output high impedance.
// - Manual soft-connect: match feedback, connect, then only host writes.
// - Manual hard-connect: connect with stored code, then host writes.
// - Host writes margin bits; device targets stored margin limits.
// - Margin requests ignored while the DAC is disconnected.
// - Off sequence drops each enable after its turn-off delay.
// - Off threshold is discharge factor times commanded voltage.
// - ON attempt above off threshold holds off, sets status, pulls alert.
// - Pin low over 10 us then released: restart delay, then turn-on delays.
// - Each channel enable maps to one control pin by config field.
`timescale 1ns/100ps
`default_nettype none
module channel_sequence_servo_margin
	import chan_seq_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Control pins and ADC readings
	input  wire logic [1:0]            control_pin,
	input  wire logic [15:0]           input_sense_pin,
	input  wire logic [3:0][15:0]      vout_reading,
	input  wire logic [3:0]            vout_valid,
	input  wire logic [3:0][9:0]       feedback_code,
	// Converter side
	output logic      [3:0]            converter_enable_out,
	output logic      [3:0][9:0]       trim_dac_out,
	output logic      [3:0]            trim_dac_connect,
	output logic      [1:0]            shared_fault_line_out,
	output logic      [1:0]            shared_fault_line_oe,
	output logic                       alert_out_n
);
	import chan_seq_pkg::*;

	typedef struct packed {
		chan_state_type [3:0]      st;
		logic [3:0][15:0]          elapsed;
		logic [3:0]                enable;
		logic [3:0]                connect;
		logic [3:0][9:0]           dac;
		logic [3:0]                servo_run;
		logic [3:0]                uv_done;
		logic [3:0][1:0]           margin;
		logic [3:0]                held_off;
		logic [3:0]                held_sticky;
		logic [3:0]                uv_fault;
		logic [3:0]                ov_fault;
		logic [15:0]               operation;
		logic [31:0]               vin_limit;
		logic [15:0]               restart_dly;
		logic [3:0][6:0][31:0]     chreg;
		logic                      vin_ok;
		logic [6:0]                tick_cnt;
		logic                      tick;
		logic [1:0][3:0]           low_cnt;
		logic [1:0]                restart_busy;
		logic [1:0][15:0]          restart_cnt;
		logic [1:0]                fault_oe;
		logic                      alert_n;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
	} state_type;

	state_type q;
	state_type n;

	function automatic logic is_chan(input logic [11:0] a);
		is_chan = a >= OFS_CH_BASE && a < OFS_CH_END && a[4:2] < 3'(NWORD);
	endfunction

	function automatic logic [1:0] chan_of(input logic [11:0] a);
		logic [11:0] off;
		off = a - OFS_CH_BASE;
		chan_of = off[6:5];
	endfunction

	function automatic logic [9:0] step_to(input logic [9:0] c,
					       input logic [9:0] t);
		step_to = (c < t) ? c + 10'h001 : c - 10'h001;
	endfunction

	// Per-channel turn-on request and off threshold
	logic [3:0]       req;
	logic [3:0][15:0] thr;
	logic [3:0][1:0]  dmode;
	logic [3:0]       pin_on;
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic [31:0] cfg;
			logic [31:0] vc;
			logic [31:0] prod;
			logic        op_on;
			assign cfg = q.chreg[g][CW_CFG];
			assign vc = q.chreg[g][CW_VCMD];
			assign op_on = q.operation[g*OP_STRIDE];
			assign pin_on[g] = control_pin[cfg[CFG_PIN]];
			assign dmode[g] = cfg[CFG_DACM +: 2];
			// Source decode, all gated by input voltage
			always_comb begin
				case (cfg[CFG_SRC +: 2])
					SRC_VIN:  req[g] = q.vin_ok;
					SRC_OP:   req[g] = q.vin_ok && op_on;
					SRC_PIN:  req[g] = q.vin_ok && pin_on[g];
					SRC_BOTH: req[g] = q.vin_ok && op_on && pin_on[g];
					default:  req[g] = 1'b0;
				endcase
			end
			// Factor is 8-bit fraction of 256
			assign prod = 32'(vc[15:0]) * 32'(vc[DISCH_LSB +: 8]);
			assign thr[g] = prod[23:8];
		end
	endgenerate

	always_comb begin
		logic        acc;
		logic        wr;
		logic [1:0]  wc;
		logic [2:0]  ww;
		logic [31:0] cfg;
		logic [15:0] rd;
		logic [15:0] tgt;
		logic [3:0]  dac_wr;
		logic        pin;
		logic [31:0] rdv;
		logic        bad;
		logic [3:0]  retarget;
		n = q;
		retarget = 4'h0;
		acc = psel && penable;
		wr = acc && q.pready && pwrite;
		wc = chan_of(paddr);
		ww = paddr[4:2];
		dac_wr = 4'h0;
		rdv = 32'h0000_0000;
		bad = 1'b0;
		cfg = 32'h0000_0000;
		rd = 16'h0000;
		tgt = 16'h0000;
		pin = 1'b0;

		// Time base shared by every timer
		n.tick = q.tick_cnt == TICK_LAST;
		n.tick_cnt = n.tick ? 7'h00 : q.tick_cnt + 7'h01;

		// Bus: one wait state, then complete
		n.pready = acc && !q.pready;
		n.pslverr = 1'b0;
		if (acc && !q.pready) begin
			case (paddr)
				OFS_OPERATION: rdv = 32'(q.operation);
				OFS_VIN_LIMIT: rdv = q.vin_limit;
				OFS_RESTART:   rdv = 32'(q.restart_dly);
				OFS_STATUS:    rdv = {16'h0000, q.ov_fault, q.uv_fault,
						      q.held_off, q.held_sticky};
				OFS_STATE: begin
					rdv = {7'h00, q.vin_ok, q.connect, q.enable,
					       4'h0, 3'(q.st[3]), 3'(q.st[2]),
					       3'(q.st[1]), 3'(q.st[0])};
				end
				default: begin
					if (is_chan(paddr)) begin
						rdv = q.chreg[wc][ww];
					end else begin
						bad = 1'b1;
					end
				end
			endcase
			n.prdata = rdv;
			n.pslverr = bad;
		end
		if (wr) begin
			case (paddr)
				OFS_OPERATION: begin
					n.operation = pwdata[15:0];
					for (int i = 0; i < NCH; i++) begin
						if (q.connect[i]) begin
							n.margin[i] = pwdata[i*OP_STRIDE+OP_MRG +: 2];
							retarget[i] = n.margin[i] != q.margin[i];
						end else begin
							// Dropped request reads back as the old margin
							n.operation[i*OP_STRIDE+OP_MRG +: 2] =
								q.operation[i*OP_STRIDE+OP_MRG +: 2];
						end
					end
				end
				OFS_VIN_LIMIT: n.vin_limit = pwdata;
				OFS_RESTART:   n.restart_dly = pwdata[15:0];
				OFS_STATUS: begin
					n.held_sticky = q.held_sticky & ~pwdata[3:0];
					n.uv_fault = q.uv_fault & ~pwdata[11:8];
					n.ov_fault = q.ov_fault & ~pwdata[15:12];
				end
				default: begin
					if (is_chan(paddr)) begin
						n.chreg[wc][ww] = pwdata;
						dac_wr[wc] = ww == CW_CFG;
					end
				end
			endcase
		end

		// Input voltage window with hysteresis
		if (input_sense_pin > q.vin_limit[15:0]) begin
			n.vin_ok = 1'b1;
		end else if (input_sense_pin < q.vin_limit[31:16]) begin
			n.vin_ok = 1'b0;
		end

		// Automatic restart per control pin
		for (int p = 0; p < NPIN; p++) begin
			if (!control_pin[p]) begin
				if (q.tick && q.low_cnt[p] <= CTRL_LOW_TK) begin
					n.low_cnt[p] = q.low_cnt[p] + 4'h1;
				end
			end else begin
				n.low_cnt[p] = 4'h0;
				if (q.low_cnt[p] > CTRL_LOW_TK) begin
					n.restart_busy[p] = 1'b1;
					n.restart_cnt[p] = 16'h0000;
				end
			end
			if (q.restart_busy[p]) begin
				if (q.restart_cnt[p] >= q.restart_dly) begin
					n.restart_busy[p] = 1'b0;
				end else if (q.tick) begin
					n.restart_cnt[p] = q.restart_cnt[p] + 16'h0001;
				end
			end
		end

		n.fault_oe = 2'b00;
		for (int i = 0; i < NCH; i++) begin
			cfg = q.chreg[i][CW_CFG];
			rd = vout_reading[i];
			pin = cfg[CFG_PIN];
			case (q.margin[i])
				MRG_HIGH: tgt = q.chreg[i][CW_MARGIN][15:0];
				MRG_LOW:  tgt = q.chreg[i][CW_MARGIN][31:16];
				default:  tgt = q.chreg[i][CW_VCMD][15:0];
			endcase
			if (q.tick && q.elapsed[i] != 16'hffff) begin
				n.elapsed[i] = q.elapsed[i] + 16'h0001;
			end
			// Overvoltage: every reading, unless margining ignores it
			if (vout_valid[i] && rd > q.chreg[i][CW_FAULT][15:0] &&
			    !(cfg[CFG_IGN_OV] && q.margin[i] != MRG_NOM)) begin
				n.ov_fault[i] = 1'b1;
			end
			if (q.uv_fault[i] && cfg[CFG_UV_OFF]) begin
				n.fault_oe[pin] = 1'b1;
			end

			case (q.st[i])
				CH_OFF: begin
					n.held_off[i] = 1'b0;
					if (req[i] && !q.restart_busy[pin]) begin
						if (rd < thr[i]) begin
							n.st[i] = CH_WAIT_ON;
							n.elapsed[i] = 16'h0000;
						end else begin
							n.held_off[i] = 1'b1;
							n.held_sticky[i] = 1'b1;
						end
					end
				end
				CH_WAIT_ON: begin
					if (q.elapsed[i] >= q.chreg[i][CW_TON][15:0]) begin
						n.enable[i] = 1'b1;
						n.st[i] = CH_RISE;
						n.elapsed[i] = 16'h0000;
						n.uv_done[i] = 1'b0;
					end
				end
				CH_RISE: begin
					if (q.elapsed[i] >= q.chreg[i][CW_TON][31:16]) begin
						case (dmode[i])
							DM_OFF: n.st[i] = CH_ON;
							DM_MAN_HARD: begin
								n.dac[i] = cfg[CFG_DAC +: DAC_W];
								n.connect[i] = 1'b1;
								n.st[i] = CH_ON;
							end
							default: begin
								if (q.dac[i] - feedback_code[i] < 10'h002 ||
								    feedback_code[i] - q.dac[i] < 10'h002) begin
									n.connect[i] = 1'b1;
									n.servo_run[i] = dmode[i] == DM_SERVO;
									n.st[i] = CH_ON;
								end else begin
									n.dac[i] = step_to(q.dac[i], feedback_code[i]);
								end
							end
						endcase
					end
				end
				CH_ON: begin
					if (vout_valid[i] && q.connect[i] && dmode[i] == DM_SERVO) begin
						if (!cfg[CFG_CONT] && cfg[CFG_WSERVO] &&
						    (rd > q.chreg[i][CW_WARN][15:0] ||
						     rd < q.chreg[i][CW_WARN][31:16])) begin
							n.servo_run[i] = 1'b1;
						end
						if (cfg[CFG_CONT] || q.servo_run[i]) begin
							if (rd < tgt && q.dac[i] != 10'h000) begin
								n.dac[i] = q.dac[i] - 10'h001;
							end else if (rd > tgt && q.dac[i] != 10'h3ff) begin
								n.dac[i] = q.dac[i] + 10'h001;
							end else if (rd == tgt && !cfg[CFG_CONT]) begin
								n.servo_run[i] = 1'b0;
							end
						end
					end
					if (dac_wr[i] && q.connect[i] && dmode[i] != DM_SERVO) begin
						n.dac[i] = pwdata[CFG_DAC +: DAC_W];
					end
				end
				CH_OFF_WAIT: begin
					if (q.elapsed[i] >= q.chreg[i][CW_TOFF][31:16]) begin
						n.enable[i] = 1'b0;
						n.connect[i] = 1'b0;
						n.servo_run[i] = 1'b0;
						n.st[i] = CH_OFF;
					end
				end
				default: n.st[i] = CH_OFF;
			endcase

			// Undervoltage check at maximum turn-on time
			if ((q.st[i] == CH_RISE || q.st[i] == CH_ON) && !q.uv_done[i] &&
			    q.elapsed[i] >= q.chreg[i][CW_TOFF][15:0]) begin
				n.uv_done[i] = 1'b1;
				if (rd < q.chreg[i][CW_FAULT][31:16]) begin
					n.uv_fault[i] = 1'b1;
					if (cfg[CFG_UV_OFF]) begin
						n.enable[i] = 1'b0;
						n.connect[i] = 1'b0;
						n.servo_run[i] = 1'b0;
						n.st[i] = CH_OFF;
					end
				end
			end

			// Turn-off paths
			if (q.restart_busy[pin]) begin
				n.st[i] = CH_OFF;
				n.enable[i] = 1'b0;
				n.connect[i] = 1'b0;
				n.servo_run[i] = 1'b0;
			end else if (!req[i] && q.st[i] != CH_OFF &&
				     q.st[i] != CH_OFF_WAIT) begin
				if (q.st[i] == CH_WAIT_ON ||
				    (!q.vin_ok && !cfg[CFG_TRACK])) begin
					n.st[i] = CH_OFF;
					n.enable[i] = 1'b0;
					n.connect[i] = 1'b0;
					n.servo_run[i] = 1'b0;
				end else begin
					n.st[i] = CH_OFF_WAIT;
					n.elapsed[i] = 16'h0000;
				end
			end
			if (dmode[i] == DM_OFF) begin
				n.connect[i] = 1'b0;
			end
			// Non-continuous servo has parked; a new target must wake it
			if (retarget[i] && n.connect[i] && dmode[i] == DM_SERVO) begin
				n.servo_run[i] = 1'b1;
			end
			if (!n.connect[i]) begin
				n.margin[i] = MRG_NOM;
			end
		end
		n.alert_n = !(|n.held_off);
	end

	// Asynchronous reset loads constants only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			for (int i = 0; i < NCH; i++) begin
				q.chreg[i][CW_VCMD] <= VCMD_RESET;
			end
			q.alert_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign converter_enable_out = q.enable;
	assign trim_dac_out = q.dac;
	assign trim_dac_connect = q.connect;
	assign shared_fault_line_out = 2'b00;
	assign shared_fault_line_oe = q.fault_oe;
	assign alert_out_n = q.alert_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_vin_gate;
		(q.st[0] == CH_OFF && !q.vin_ok) |=> q.st[0] == CH_OFF;
	endproperty
	a_vin_gate: assert property (p_vin_gate) else $error("on without vin");

	property p_vin_off;
		(!q.vin_ok && !q.chreg[0][CW_CFG][CFG_TRACK] &&
		 q.st[0] == CH_ON && !q.restart_busy[q.chreg[0][CW_CFG][CFG_PIN]])
		|=> q.st[0] == CH_OFF && !q.enable[0];
	endproperty
	a_vin_off: assert property (p_vin_off) else $error("no immediate off");

	property p_enable_src;
		$rose(q.enable[0]) |-> $past(q.st[0]) == CH_WAIT_ON &&
			$past(q.elapsed[0]) >= $past(q.chreg[0][CW_TON][15:0]);
	endproperty
	a_enable_src: assert property (p_enable_src) else $error("early enable");

	property p_dac_off;
		dmode[1] == DM_OFF |=> !q.connect[1];
	endproperty
	a_dac_off: assert property (p_dac_off) else $error("dac connected");

	property p_margin_ignore;
		!q.connect[1] |=> q.margin[1] == MRG_NOM;
	endproperty
	a_margin_ignore: assert property (p_margin_ignore) else $error("margin taken");

	property p_hold_off;
		(q.st[0] == CH_OFF && req[0] && vout_reading[0] >= thr[0] &&
		 !q.restart_busy[q.chreg[0][CW_CFG][CFG_PIN]])
		|=> q.held_off[0] && q.held_sticky[0] && !alert_out_n;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("no hold off");

	property p_restart;
		q.restart_busy[q.chreg[3][CW_CFG][CFG_PIN]] |=> !q.enable[3];
	endproperty
	a_restart: assert property (p_restart) else $error("enable in restart");

	property p_servo_stop;
		(q.st[0] == CH_ON && !q.servo_run[0] && !q.chreg[0][CW_CFG][CFG_CONT]
		 && !q.chreg[0][CW_CFG][CFG_WSERVO] && dmode[0] == DM_SERVO)
		|=> $stable(q.dac[0]);
	endproperty
	a_servo_stop: assert property (p_servo_stop) else $error("dac moved");

	c_on: cover property ($rose(q.st[0] == CH_ON) && q.connect[0]);
	c_hold: cover property ($rose(q.held_off[0]));
	c_restart: cover property ($fell(q.restart_busy[1]));
	c_margin: cover property (q.margin[0] == MRG_HIGH);
endmodule
`default_nettype wire

// file: verification/converter_model.sv
`timescale 1ns/100ps
`default_nettype none
module converter_model
	import chan_seq_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// Converter controls from the block
	input  wire logic [3:0]      enable,
	input  wire logic [3:0][9:0] dac,
	input  wire logic [3:0]      connect,
	// Bench steering
	input  wire logic [3:0]      hold_high,
	// Readings back to the block
	output logic      [3:0][15:0] vout_reading,
	output logic      [3:0]       vout_valid,
	output logic      [3:0][9:0]  feedback_code
);
	logic [3:0] div;

	assign feedback_code = {4{10'h180}};
	// A reading every 16 cycles keeps the servo slow enough to watch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= 4'h0;
			vout_valid <= 4'h0;
			vout_reading <= '0;
		end else begin
			div <= div + 4'h1;
			vout_valid <= {4{div == 4'hf}};
			if (div == 4'hf) begin
				for (int i = 0; i < 4; i++) begin
					// Higher trim code lowers the output, as on a divider node
					if (enable[i])
						vout_reading[i] <= 16'h1000 + 16'(feedback_code[i])
							- 16'(connect[i] ? dac[i] : feedback_code[i]);
					// Held channel keeps its last reading, mimicking an output that does not discharge
					else if (!hold_high[i])
						vout_reading[i] <= vout_reading[i] >> 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/test_channel_sequence_servo_margin.sv
`timescale 1ns/100ps
`default_nettype none
module test_channel_sequence_servo_margin;
	import chan_seq_pkg::*;
	logic             clk;
	logic             rst_n;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [11:0]      paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             alert_out_n;
	logic [1:0]       control_pin;
	logic [1:0]       fault_out;
	logic [1:0]       fault_oe;
	logic [15:0]      input_sense_pin;
	logic [3:0][15:0] vout_reading;
	logic [3:0]       vout_valid;
	logic [3:0]       converter_enable_out;
	logic [3:0]       trim_dac_connect;
	logic [3:0]       hold_high;
	logic [3:0][9:0]  feedback_code;
	logic [3:0][9:0]  trim_dac_out;
	logic [32:0]      exp_q[$];
	logic [9:0]       code;
	logic [11:0]      a;
	int               n_mismatch;
	int               total_checks;
	int               n;

	channel_sequence_servo_margin u_dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .control_pin(control_pin),
		.input_sense_pin(input_sense_pin), .vout_reading(vout_reading),
		.vout_valid(vout_valid), .feedback_code(feedback_code),
		.converter_enable_out(converter_enable_out),
		.trim_dac_out(trim_dac_out), .trim_dac_connect(trim_dac_connect),
		.shared_fault_line_out(fault_out), .shared_fault_line_oe(fault_oe),
		.alert_out_n(alert_out_n)
	);

	converter_model u_conv (
		.clk(clk), .rst_n(rst_n), .enable(converter_enable_out),
		.dac(trim_dac_out), .connect(trim_dac_connect),
		.hold_high(hold_high), .vout_reading(vout_reading),
		.vout_valid(vout_valid), .feedback_code(feedback_code)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic complete_run();
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] near(input logic [9:0] x, input logic [9:0] y);
		return {31'h0, ((x > y) ? x - y : y - x) <= 10'h1};
	endfunction

	// Request held until pready is seen high, then released for one edge
	task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		if (k >= 40)
			n_mismatch++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic err);
		exp_q.push_back({err, e});
		xfer(1'b0, ad, 32'h0);
	endtask

	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			check({31'h0, pslverr}, {31'h0, exp_q[0][32]});
			check(prdata, exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
	end

	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		control_pin = 2'h0;
		input_sense_pin = 16'h0;
		hold_high = 4'h0;
		void'($urandom(62299));
		code = 10'($urandom_range(1000, 1));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check(32'(converter_enable_out), 32'h0);
		check(32'(trim_dac_connect), 32'h0);
		rd(OFS_STATUS, 32'h0, 1'b0);
		rd(OFS_CH_BASE + 12'h00c, VCMD_RESET, 1'b0);
		rd(12'hffc, 32'h0, 1'b1);
		xfer(1'b1, OFS_VIN_LIMIT, 32'h0800_1000);
		xfer(1'b1, OFS_RESTART, 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			a = OFS_CH_BASE + 12'(32 * i);
			xfer(1'b1, a + 12'h004, 32'h0002_0003);
			xfer(1'b1, a + 12'h008, 32'h0002_0020);
			xfer(1'b1, a + 12'h00c, 32'h00c0_1000);
			xfer(1'b1, a + 12'h014, 32'h0000_ffff);
		end
		xfer(1'b1, OFS_CH_BASE + 12'h034, 32'h0000_0fff);
		// Sources: command, command while disconnected, manual hard,
		// pin 1 with manual soft-connect
		xfer(1'b1, OFS_CH_BASE, 32'h0000_0001);
		xfer(1'b1, OFS_CH_BASE + 12'h020, 32'h0000_0011);
		xfer(1'b1, OFS_CH_BASE + 12'h040, {6'h0, code, 16'h0031});
		xfer(1'b1, OFS_CH_BASE + 12'h060, 32'h0000_002a);
		xfer(1'b1, OFS_CH_BASE + 12'h010, 32'h0f00_1100);
		xfer(1'b1, OFS_OPERATION, 32'h0000_0001);
		repeat (600) @(posedge clk);
		check(32'(converter_enable_out), 32'h0);
		rd(OFS_STATE, 32'h0, 1'b0);
		input_sense_pin <= 16'($urandom_range(16'hffff, 16'h1001));
		xfer(1'b1, OFS_OPERATION, 32'h0000_0151);
		repeat (200) @(posedge clk);
		check(32'(converter_enable_out[2:0]), 32'h0);
		repeat (250) @(posedge clk);
		check(32'(converter_enable_out[2:0]), 32'h7);
		rd(OFS_OPERATION, 32'h0000_0111, 1'b0);
		for (n = 0; n < 800 && trim_dac_connect[0] !== 1'b1; n++) @(posedge clk);
		check(near(trim_dac_out[0], feedback_code[0]), 32'h1);
		for (n = 0; n < 800 && trim_dac_connect[2] !== 1'b1; n++) @(posedge clk);
		check(32'(trim_dac_out[2]), 32'(code));
		check(32'(trim_dac_connect[1]), 32'h0);
		repeat (400) @(posedge clk);
		check(32'(trim_dac_out[0]), 32'h180);
		xfer(1'b1, OFS_CH_BASE + 12'h040, {6'h0, 10'h03c, 16'h0031});
		repeat (4) @(posedge clk);
		check(32'(trim_dac_out[2]), 32'h03c);
		// Margin high 0x1100 needs the code 0x100 below the feedback code
		xfer(1'b1, OFS_OPERATION, 32'h0000_0115);
		repeat (5000) @(posedge clk);
		check(32'(trim_dac_out[0]), 32'h080);
		hold_high <= 4'h1;
		xfer(1'b1, OFS_OPERATION, 32'h0000_0110);
		repeat (50) @(posedge clk);
		check(32'(converter_enable_out[0]), 32'h1);
		repeat (300) @(posedge clk);
		check(32'(converter_enable_out[0]), 32'h0);
		xfer(1'b1, OFS_OPERATION, 32'h0000_0111);
		repeat (600) @(posedge clk);
		check(32'(converter_enable_out[0]), 32'h0);
		check(32'(alert_out_n), 32'h0);
		rd(OFS_STATUS, 32'h0000_2011, 1'b0);
		hold_high <= 4'h0;
		for (n = 0; n < 1000 && converter_enable_out[0] !== 1'b1; n++) @(posedge clk);
		check(32'(converter_enable_out[0]), 32'h1);
		check(32'(converter_enable_out[3]), 32'h0);
		// Low since reset counts as a long low, so this rise restarts too
		control_pin[1] <= 1'b1;
		repeat (800) @(posedge clk);
		check(32'(converter_enable_out[3]), 32'h1);
		control_pin[1] <= 1'b0;
		repeat (1200) @(posedge clk);
		control_pin[1] <= 1'b1;
		repeat (450) @(posedge clk);
		check(32'(converter_enable_out[3]), 32'h0);
		check(32'(converter_enable_out[0]), 32'h1);
		check(32'({fault_out, fault_oe}), 32'h0);
		repeat (400) @(posedge clk);
		check(32'(converter_enable_out[3]), 32'h1);
		for (n = 0; n < 800 && trim_dac_connect[3] !== 1'b1; n++) @(posedge clk);
		check(near(trim_dac_out[3], feedback_code[3]), 32'h1);
		xfer(1'b1, OFS_CH_BASE + 12'h060, {6'h0, 10'h055, 16'h002a});
		repeat (4) @(posedge clk);
		check(32'(trim_dac_out[3]), 32'h055);
		input_sense_pin <= 16'h0400;
		repeat (20) @(posedge clk);
		check(32'(converter_enable_out), 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
